// ==== logic/spi_port_pkg.sv ====
// Constants, register map and state types of the buffered SPI port.
// Assumes a 10 MHz system clock and a classic Wishbone register bus.
package spi_port_pkg;

  // System clock in kHz, used to derive the serial clock divider
  localparam int unsigned CLK_KHZ = 10000;

  // Register byte offsets
  localparam logic [7:0] A_CTRL     = 8'h00;
  localparam logic [7:0] A_RATE     = 8'h04;
  localparam logic [7:0] A_QUICK    = 8'h08;
  localparam logic [7:0] A_TERM     = 8'h0C;
  localparam logic [7:0] A_FILL     = 8'h10;
  localparam logic [7:0] A_RXSIZE   = 8'h14;
  localparam logic [7:0] A_TXSIZE   = 8'h18;
  localparam logic [7:0] A_RXDATA   = 8'h1C;
  localparam logic [7:0] A_TXDATA   = 8'h20;
  localparam logic [7:0] A_STATUS   = 8'h24;
  localparam logic [7:0] A_PROCLEN  = 8'h28;
  localparam logic [7:0] A_IRQ_STAT = 8'h2C;
  localparam logic [7:0] A_IRQ_CLR  = 8'h30;
  localparam logic [7:0] A_IRQ_EN   = 8'h34;

  // Control register field positions
  localparam int B_ROLE    = 0;   // Two bits
  localparam int B_EDGE    = 2;
  localparam int B_RXMODE  = 3;   // Two bits
  localparam int B_TXMODE  = 5;   // Two bits
  localparam int B_RXLSB   = 7;
  localparam int B_TXLSB   = 8;
  localparam int B_FULLEN  = 9;
  localparam int B_RSSEN   = 10;
  localparam int B_HALTEN  = 11;
  localparam int B_TSSEN   = 12;
  localparam int B_STRIP   = 13;
  localparam int B_ENCODE  = 14;  // Three bits
  // Quick setup field positions
  localparam int Q_SLAVE   = 0;
  localparam int Q_FALL    = 1;
  localparam int Q_CMD     = 2;
  localparam int Q_RATE    = 6;   // Ten bits

  // Role, path mode and text encoding codes
  localparam logic [1:0] ROLE_NONE   = 2'h0;
  localparam logic [1:0] ROLE_MASTER = 2'h1;
  localparam logic [1:0] ROLE_SLAVE  = 2'h2;
  localparam logic [1:0] PATH_OFF    = 2'h0;
  localparam logic [1:0] PATH_BUF    = 2'h1;
  localparam logic [1:0] PATH_CMD    = 2'h2;  // Rx: command source, tx: echo
  localparam logic [2:0] ENC_WIDE    = 3'h1;
  localparam logic [2:0] ENC_WIDE_RAW = 3'h4;

  // Interrupt event bit positions
  localparam int EV_RX   = 0;  // Byte received
  localparam int EV_PROC = 1;  // Termination sequence seen
  localparam int EV_OVR  = 2;  // Byte lost, receive buffer full
  localparam int EV_TXE  = 3;  // Transmit buffer drained

  // Reset values and limits
  localparam logic [9:0]  RATE_MIN    = 10'd20;
  localparam logic [9:0]  RATE_MAX    = 10'd1000;
  localparam logic [9:0]  RATE_RST    = 10'd100;
  localparam logic [7:0]  HALF_RST    = 8'd50;
  localparam logic [13:0] BUF_DEPTH   = 14'd8192;
  localparam logic [15:0] TERM_RST    = 16'h003B;
  localparam logic [1:0]  TERM_LEN_RST = 2'h1;
  localparam logic [7:0]  FILL_RST    = 8'hFF;

  // Master clock generator states
  typedef enum logic [0:0] {
    M_IDLE = 1'b0,
    M_RUN  = 1'b1
  } mst_e;

endpackage

// ==== logic/buffered_spi_port.sv ====
// Buffered SPI port: master or slave shifter, rx and tx byte buffers,
// termination detection and a Wishbone register file with interrupts.
// Assumes pins arrive unsynchronised; clk_i is 10 MHz, rst_i synchronous.

// Notes on behaviour
// - Role master, slave or off; off after reset
// - Sampling edge selectable, rising by default
// - Master rate 20 to 1000 kbit/s, default 100
// - Quick setting sets role, edge, command, rate
// - Rx path buffer, command source or off
// - Terminator sequence hands buffered bytes to processing
// - Terminator bytes stripped or kept, as configured
// - Rx buffer capacity programmable, default 8192 bytes
// - Rx bit order MSB or LSB first
// - Optional rx buffer full output
// - Optional slave select input gates receive
// - Tx path buffer, command echo or off
// - Filler byte sent in slave role when tx buffer empty
// - Tx buffer capacity programmable, default 8192 bytes
// - Tx bit order MSB or LSB first
// - Master pauses while halt input asserted, optional
// - Master optionally drives select output during transfers
// - Buffered data encoding single, wide, multibyte, raw
module buffered_spi_port (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Serial clock, two-way
  input  wire logic        sclk_i,
  output logic             sclk_o,
  output logic             sclk_oe_o,
  // Serial data
  input  wire logic        ser_in_i,
  output logic             ser_out_o,
  output logic             ser_out_oe_o,
  // Hardware handshakes
  input  wire logic        tx_halt_i,
  input  wire logic        rx_slave_select_n_i,
  output logic             tx_slave_select_n_o,
  output logic             rx_full_flag_o,
  // Interrupt
  output logic             irq_o
);

  // Whole block state
  typedef struct packed {
    logic [1:0]  role;
    logic        edge_fall;
    logic [1:0]  rx_mode;
    logic [1:0]  tx_mode;
    logic        rx_lsb;
    logic        tx_lsb;
    logic        full_en;
    logic        rss_en;
    logic        halt_en;
    logic        tss_en;
    logic        strip;
    logic [2:0]  encode;
    logic [9:0]  rate;
    logic [7:0]  half;
    logic [15:0] term;
    logic [1:0]  term_len;
    logic [7:0]  fill;
    logic [13:0] rx_size;
    logic [13:0] tx_size;
    logic [12:0] rx_wr;
    logic [12:0] rx_rd;
    logic [13:0] rx_cnt;
    logic [12:0] tx_wr;
    logic [12:0] tx_rd;
    logic [13:0] tx_cnt;
    logic [13:0] proc_len;
    logic [7:0]  prev;
    logic        byte_odd;
    logic [3:0]  irq_stat;
    logic [3:0]  irq_en;
    logic [3:0]  sy1;       // Synchroniser first stage
    logic [3:0]  sy2;       // Synchroniser second stage
    logic        sclk_p;    // Previous synchronised serial clock
    spi_port_pkg::mst_e mst;
    logic [7:0]  div;
    logic        sclk_out;
    logic        sclk_oe;
    logic [3:0]  bit_cnt;
    logic [7:0]  sh_tx;
    logic [7:0]  sh_rx;
    logic        ser_out;
    logic        ser_oe;
    logic        primed;
    logic        ss_out_n;
    logic        ack;
    logic [31:0] dat;
    logic        rx_full;
    logic        irq;
  } state_s;

  state_s s;                          // Current state
  state_s next_s;                     // Next state
  logic [7:0]  rx_mem [0:8191];       // Receive byte ring
  logic [7:0]  tx_mem [0:8191];       // Transmit byte ring
  logic        rx_we;                 // Receive ring write strobe
  logic [7:0]  rx_wd;                 // Receive ring write data
  logic        tx_we;                 // Transmit ring write strobe
  logic [7:0]  tx_wd;                 // Transmit ring write data

  // First bit to present for a byte
  function automatic logic first_bit(input logic [7:0] b, input logic lsb);
    return lsb ? b[0] : b[7];
  endfunction

  // Byte after one bit has gone out
  function automatic logic [7:0] shift_out(input logic [7:0] b,
                                           input logic lsb);
    return lsb ? {1'b0, b[7:1]} : {b[6:0], 1'b0};
  endfunction

  // Assemble one incoming bit into the byte
  function automatic logic [7:0] shift_in(input logic [7:0] b,
                                          input logic d, input logic lsb);
    return lsb ? {d, b[7:1]} : {b[6:0], d};
  endfunction

  // Effective capacity; zero or oversize means the full ring
  function automatic logic [13:0] cap(input logic [13:0] sz);
    return (sz == 14'h0 || sz > spi_port_pkg::BUF_DEPTH) ?
           spi_port_pkg::BUF_DEPTH : sz;
  endfunction

  // Keep rate inside the legal band
  function automatic logic [9:0] clamp_rate(input logic [9:0] r);
    if (r < spi_port_pkg::RATE_MIN)
      return spi_port_pkg::RATE_MIN;
    if (r > spi_port_pkg::RATE_MAX)
      return spi_port_pkg::RATE_MAX;
    return r;
  endfunction

  // Merge written bytes under the byte enables
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i])
        r[i*8 +: 8] = d[i*8 +: 8];
    end
    return r;
  endfunction

  // Next-state logic
  always_comb begin
    logic [31:0] cur;       // Readback of the addressed register
    logic [31:0] m;         // Merged write data
    logic        acc;       // Bus access completes this edge
    logic        got;       // A whole byte came in
    logic [7:0]  gbyte;     // That byte
    logic        load;      // Shifter wants a new tx byte
    logic [7:0]  tx_next;   // Byte that will go out next
    logic        tx_pop;
    logic        tx_push;
    logic        rx_pop;
    logic        rx_push;
    logic        rx_unpush;
    logic        echo;
    logic        hit;
    logic        sel_ok;
    logic        samp;
    logic        shft;
    logic        rise;
    logic        fall;
    logic        wide;
    next_s   = s;
    cur      = 32'h0;
    m        = 32'h0;
    got      = 1'b0;
    gbyte    = 8'h0;
    load     = 1'b0;
    tx_pop   = 1'b0;
    tx_push  = 1'b0;
    rx_pop   = 1'b0;
    rx_push  = 1'b0;
    rx_unpush = 1'b0;
    echo     = 1'b0;
    hit      = 1'b0;
    sel_ok   = 1'b0;
    samp     = 1'b0;
    shft     = 1'b0;
    rx_we    = 1'b0;
    rx_wd    = 8'h0;
    tx_we    = 1'b0;
    tx_wd    = 8'h0;
    acc      = wb_cyc_i & wb_stb_i & s.ack;
    wide     = (s.encode == spi_port_pkg::ENC_WIDE) ||
               (s.encode == spi_port_pkg::ENC_WIDE_RAW);
    // Tx byte source: buffer when active and holding data, else filler
    tx_next  = (s.tx_mode != spi_port_pkg::PATH_OFF && s.tx_cnt != 14'h0) ?
               tx_mem[s.tx_rd] : s.fill;

    // Pin synchronisers; only sy2 is read by logic
    next_s.sy1 = {rx_slave_select_n_i, tx_halt_i, ser_in_i, sclk_i};
    next_s.sy2 = s.sy1;
    next_s.sclk_p = s.sy2[0];
    rise = s.sy2[0] & ~s.sclk_p;
    fall = ~s.sy2[0] & s.sclk_p;

    // Register readback
    unique case (wb_adr_i)
      spi_port_pkg::A_CTRL: begin
        cur[spi_port_pkg::B_ROLE +: 2]   = s.role;
        cur[spi_port_pkg::B_EDGE]        = s.edge_fall;
        cur[spi_port_pkg::B_RXMODE +: 2] = s.rx_mode;
        cur[spi_port_pkg::B_TXMODE +: 2] = s.tx_mode;
        cur[spi_port_pkg::B_RXLSB]       = s.rx_lsb;
        cur[spi_port_pkg::B_TXLSB]       = s.tx_lsb;
        cur[spi_port_pkg::B_FULLEN]      = s.full_en;
        cur[spi_port_pkg::B_RSSEN]       = s.rss_en;
        cur[spi_port_pkg::B_HALTEN]      = s.halt_en;
        cur[spi_port_pkg::B_TSSEN]       = s.tss_en;
        cur[spi_port_pkg::B_STRIP]       = s.strip;
        cur[spi_port_pkg::B_ENCODE +: 3] = s.encode;
      end
      spi_port_pkg::A_RATE:     cur[9:0]  = s.rate;
      spi_port_pkg::A_TERM:     cur[17:0] = {s.term_len, s.term};
      spi_port_pkg::A_FILL:     cur[7:0]  = s.fill;
      spi_port_pkg::A_RXSIZE:   cur[13:0] = s.rx_size;
      spi_port_pkg::A_TXSIZE:   cur[13:0] = s.tx_size;
      spi_port_pkg::A_RXDATA:   cur[7:0]  =
        (s.rx_cnt != 14'h0) ? rx_mem[s.rx_rd] : 8'h0;
      spi_port_pkg::A_STATUS:   cur = {1'b0, s.mst == spi_port_pkg::M_RUN,
                                       s.tx_cnt, 2'b00, s.rx_cnt};
      spi_port_pkg::A_PROCLEN:  cur[13:0] = s.proc_len;
      spi_port_pkg::A_IRQ_STAT: cur[3:0]  = s.irq_stat;
      spi_port_pkg::A_IRQ_EN:   cur[3:0]  = s.irq_en;
      default:                  cur = 32'h0;  // Write-only or unmapped
    endcase

    // Bus answer one edge after the request, dropped the next cycle
    next_s.ack = wb_cyc_i & wb_stb_i & ~s.ack;
    next_s.dat = (next_s.ack && !wb_we_i) ? cur : 32'h0;

    // Register writes take effect at the acknowledging edge
    m = merge(cur, wb_dat_i, wb_sel_i);
    if (acc && wb_we_i) begin
      unique case (wb_adr_i)
        spi_port_pkg::A_CTRL: begin
          next_s.role      = m[spi_port_pkg::B_ROLE +: 2];
          next_s.edge_fall = m[spi_port_pkg::B_EDGE];
          next_s.rx_mode   = m[spi_port_pkg::B_RXMODE +: 2];
          next_s.tx_mode   = m[spi_port_pkg::B_TXMODE +: 2];
          next_s.rx_lsb    = m[spi_port_pkg::B_RXLSB];
          next_s.tx_lsb    = m[spi_port_pkg::B_TXLSB];
          next_s.full_en   = m[spi_port_pkg::B_FULLEN];
          next_s.rss_en    = m[spi_port_pkg::B_RSSEN];
          next_s.halt_en   = m[spi_port_pkg::B_HALTEN];
          next_s.tss_en    = m[spi_port_pkg::B_TSSEN];
          next_s.strip     = m[spi_port_pkg::B_STRIP];
          next_s.encode    = m[spi_port_pkg::B_ENCODE +: 3];
        end
        spi_port_pkg::A_RATE:
          next_s.rate = clamp_rate(m[9:0]);
        spi_port_pkg::A_QUICK: begin
          // One word sets role, edge, command handling and rate
          next_s.role = m[spi_port_pkg::Q_SLAVE] ?
            spi_port_pkg::ROLE_SLAVE : spi_port_pkg::ROLE_MASTER;
          next_s.edge_fall = m[spi_port_pkg::Q_FALL];
          next_s.rx_mode = m[spi_port_pkg::Q_CMD] ?
            spi_port_pkg::PATH_CMD : spi_port_pkg::PATH_BUF;
          next_s.rate = clamp_rate(m[spi_port_pkg::Q_RATE +: 10]);
        end
        spi_port_pkg::A_TERM: begin
          next_s.term     = m[15:0];
          next_s.term_len = m[17:16];
        end
        spi_port_pkg::A_FILL:   next_s.fill    = m[7:0];
        spi_port_pkg::A_RXSIZE: next_s.rx_size = m[13:0];
        spi_port_pkg::A_TXSIZE: next_s.tx_size = m[13:0];
        spi_port_pkg::A_TXDATA:
          // Bytes beyond capacity are dropped; software polls tx count
          tx_push = wb_sel_i[0] && (s.tx_cnt < cap(s.tx_size));
        spi_port_pkg::A_IRQ_CLR:
          next_s.irq_stat = s.irq_stat & ~m[3:0];
        spi_port_pkg::A_IRQ_EN: next_s.irq_en = m[3:0];
        default: ;
      endcase
    end
    // Reading the data register consumes one byte
    rx_pop = acc && !wb_we_i && wb_adr_i == spi_port_pkg::A_RXDATA &&
             s.rx_cnt != 14'h0;
    // Divider follows the rate: half a bit period in system clocks
    next_s.half = 8'(half_clocks(next_s.rate));

    // Serial engine
    next_s.sclk_oe = (s.role == spi_port_pkg::ROLE_MASTER);
    if (s.role == spi_port_pkg::ROLE_MASTER) begin
      next_s.ser_oe = 1'b1;
      next_s.primed = 1'b0;
      unique case (s.mst)
        spi_port_pkg::M_IDLE: begin
          // Clock rests at the level opposite the sampling edge
          next_s.sclk_out = s.edge_fall;
          next_s.ss_out_n = 1'b1;
          if (s.tx_mode != spi_port_pkg::PATH_OFF && s.tx_cnt != 14'h0 &&
              !(s.halt_en && s.sy2[2])) begin
            load = 1'b1;
            next_s.mst = spi_port_pkg::M_RUN;
            next_s.div = s.half;
            next_s.bit_cnt = 4'h0;
            next_s.ss_out_n = ~s.tss_en;
          end
        end
        spi_port_pkg::M_RUN: begin
          if (s.div > 8'h1) begin
            next_s.div = s.div - 8'h1;
          end else begin
            next_s.div = s.half;
            next_s.sclk_out = ~s.sclk_out;
            if (s.sclk_out == s.edge_fall) begin
              // Leaving rest level: this is the sampling edge
              next_s.sh_rx = shift_in(s.sh_rx, s.sy2[1], s.rx_lsb);
              next_s.bit_cnt = s.bit_cnt + 4'h1;
            end else if (s.bit_cnt == 4'h8) begin
              got = 1'b1;
              gbyte = s.sh_rx;
              next_s.mst = spi_port_pkg::M_IDLE;
              // Cleared so a later slave role starts at bit zero
              next_s.bit_cnt = 4'h0;
            end else begin
              next_s.ser_out = first_bit(s.sh_tx, s.tx_lsb);
              next_s.sh_tx = shift_out(s.sh_tx, s.tx_lsb);
            end
          end
        end
      endcase
    end else begin
      // Slave or off: master clock generator parked
      next_s.mst = spi_port_pkg::M_IDLE;
      next_s.sclk_out = s.edge_fall;
      next_s.ss_out_n = 1'b1;
      sel_ok = !s.rss_en || !s.sy2[3];
      samp = s.edge_fall ? fall : rise;
      shft = s.edge_fall ? rise : fall;
      next_s.ser_oe = (s.role == spi_port_pkg::ROLE_SLAVE) && sel_ok;
      if (s.role != spi_port_pkg::ROLE_SLAVE || !sel_ok) begin
        // Deselect aborts a partial byte
        next_s.bit_cnt = 4'h0;
        next_s.primed = 1'b0;
      end else if (samp) begin
        // Only the external clock moves the shifter
        next_s.sh_rx = shift_in(s.sh_rx, s.sy2[1], s.rx_lsb);
        if (s.bit_cnt == 4'h7) begin
          got = 1'b1;
          gbyte = shift_in(s.sh_rx, s.sy2[1], s.rx_lsb);
          next_s.bit_cnt = 4'h0;
          next_s.primed = 1'b0;
        end else begin
          next_s.bit_cnt = s.bit_cnt + 4'h1;
        end
      end else if (shft && s.bit_cnt != 4'h0) begin
        next_s.ser_out = first_bit(s.sh_tx, s.tx_lsb);
        next_s.sh_tx = shift_out(s.sh_tx, s.tx_lsb);
      end else if (s.bit_cnt == 4'h0 && !s.primed) begin
        load = 1'b1;
        next_s.primed = 1'b1;
      end
    end
    // Put the next byte on the line: first bit out, rest queued
    if (load) begin
      tx_pop = (s.tx_mode != spi_port_pkg::PATH_OFF) && s.tx_cnt != 14'h0;
      next_s.ser_out = first_bit(tx_next, s.tx_lsb);
      next_s.sh_tx = shift_out(tx_next, s.tx_lsb);
    end

    // Received byte handling
    if (got && s.rx_mode != spi_port_pkg::PATH_OFF) begin
      next_s.irq_stat[spi_port_pkg::EV_RX] = 1'b1;
      next_s.prev = gbyte;
      next_s.byte_odd = ~s.byte_odd;
      // Wide text only matches on a completed character pair
      hit = (!wide || s.byte_odd) && s.term_len != 2'h0 &&
            gbyte == s.term[7:0] &&
            (s.term_len == 2'h1 || s.prev == s.term[15:8]);
      if (hit && s.strip) begin
        // Drop the last byte and take back any stored lead byte
        rx_unpush = (s.term_len == 2'h2) && s.rx_cnt != 14'h0;
      end else if (s.rx_cnt >= cap(s.rx_size)) begin
        next_s.irq_stat[spi_port_pkg::EV_OVR] = 1'b1;
      end else begin
        rx_push = 1'b1;
      end
      if (hit) begin
        next_s.irq_stat[spi_port_pkg::EV_PROC] = 1'b1;
        next_s.proc_len = 14'(s.rx_cnt + {13'h0, rx_push} -
                              {13'h0, rx_unpush});
      end
      // Echo mode copies received bytes to the transmit side
      echo = s.tx_mode == spi_port_pkg::PATH_CMD &&
             s.tx_cnt < cap(s.tx_size) && !tx_push;
    end
    if (got && s.rx_mode == spi_port_pkg::PATH_OFF &&
        s.tx_mode == spi_port_pkg::PATH_CMD)
      echo = 1'b0;

    // Ring writes and pointer bookkeeping
    rx_we = rx_push;
    rx_wd = gbyte;
    if (rx_push)
      next_s.rx_wr = s.rx_wr + 13'h1;
    if (rx_unpush)
      next_s.rx_wr = s.rx_wr - 13'h1;
    if (rx_pop)
      next_s.rx_rd = s.rx_rd + 13'h1;
    next_s.rx_cnt = 14'(s.rx_cnt + {13'h0, rx_push} - {13'h0, rx_pop} -
                        {13'h0, rx_unpush});
    tx_we = tx_push | echo;
    tx_wd = tx_push ? wb_dat_i[7:0] : gbyte;
    if (tx_we)
      next_s.tx_wr = s.tx_wr + 13'h1;
    if (tx_pop)
      next_s.tx_rd = s.tx_rd + 13'h1;
    next_s.tx_cnt = 14'(s.tx_cnt + {13'h0, tx_we} - {13'h0, tx_pop});
    // Event set wins over a clear in the same cycle
    if (tx_pop && next_s.tx_cnt == 14'h0)
      next_s.irq_stat[spi_port_pkg::EV_TXE] = 1'b1;

    // Registered outputs
    next_s.rx_full = next_s.full_en &&
                     next_s.rx_cnt >= cap(next_s.rx_size);
    next_s.irq = |(next_s.irq_stat & next_s.irq_en);
  end

  // Divider half period from rate in kbit/s
  function automatic logic [31:0] half_clocks(input logic [9:0] r);
    return 32'(spi_port_pkg::CLK_KHZ) / (32'(r) * 32'd2);
  endfunction

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.role     <= spi_port_pkg::ROLE_NONE;
      s.rx_mode  <= spi_port_pkg::PATH_OFF;
      s.rate     <= spi_port_pkg::RATE_RST;
      s.half     <= spi_port_pkg::HALF_RST;
      s.term     <= spi_port_pkg::TERM_RST;
      s.term_len <= spi_port_pkg::TERM_LEN_RST;
      s.fill     <= spi_port_pkg::FILL_RST;
      s.rx_size  <= spi_port_pkg::BUF_DEPTH;
      s.tx_size  <= spi_port_pkg::BUF_DEPTH;
      s.ss_out_n <= 1'b1;
      s.sy1      <= 4'hF;
      s.sy2      <= 4'hF;
      s.mst      <= spi_port_pkg::M_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // Byte rings; no reset needed, counts guard the contents
  always_ff @(posedge clk_i) begin
    if (rx_we)
      rx_mem[s.rx_wr] <= rx_wd;
    if (tx_we)
      tx_mem[s.tx_wr] <= tx_wd;
  end

  // Outputs straight from state flops
  assign wb_dat_o            = s.dat;
  assign wb_ack_o            = s.ack;
  assign sclk_o              = s.sclk_out;
  assign sclk_oe_o           = s.sclk_oe;
  assign ser_out_o           = s.ser_out;
  assign ser_out_oe_o        = s.ser_oe;
  assign tx_slave_select_n_o = s.ss_out_n;
  assign rx_full_flag_o      = s.rx_full;
  assign irq_o               = s.irq;

endmodule // buffered_spi_port

// ==== testbench/spi_port_props.sv ====
// Port-level checker for the buffered SPI port.
// Assumes one clock domain with a synchronous active-high reset.
module spi_port_props (
  // Watched ports
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic        sclk_o,
  input wire logic        sclk_oe_o,
  input wire logic        ser_out_oe_o,
  input wire logic        tx_slave_select_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // New bus request not yet answered
  sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  // Steady master clock, so role changes do not count as edges
  sequence run_s; sclk_oe_o && $past(sclk_oe_o); endsequence
  ack_next_a:
    assert property (req_s |=> wb_ack_o) else $error("ack late");
  ack_once_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  dat_idle_a:
    assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("dat");
  off_reset_a:
    assert property ($fell(rst_i) |-> !sclk_oe_o && !ser_out_oe_o)
      else $error("role not off");
  oe_tie_a:
    assert property (sclk_oe_o |-> ser_out_oe_o) else $error("data oe");
  sclk_high_a:
    assert property (run_s ##0 $rose(sclk_o) |-> sclk_o [*5])
      else $error("short high");
  sclk_low_a:
    assert property (run_s ##0 $fell(sclk_o) |-> !sclk_o [*5])
      else $error("short low");
  sel_master_a:
    assert property (!tx_slave_select_n_o |-> sclk_oe_o) else $error("ss");
endmodule // spi_port_props
bind buffered_spi_port spi_port_props spi_port_props_i (.*);

// ==== testbench/spi_far_end.sv ====
// Far-end SPI slave standing in for the host controller.
// Assumes rising-edge sampling; drives data before the first edge.
module spi_far_end (
  input  wire logic       sclk_i,  // Serial clock from the port
  input  wire logic       sel_n_i, // Select, active low
  input  wire logic       mosi_i,  // Data from the port
  input  wire logic [7:0] send_i,  // Byte to return
  output logic            miso_o,  // Data to the port
  output logic      [7:0] got_o    // Last byte captured
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh; // Outgoing shift register
  // Load on select, capture on rising, shift on falling
  always @(negedge sel_n_i) sh = send_i;
  always @(posedge sclk_i) if (!sel_n_i) got_o = {got_o[6:0], mosi_i};
  always @(negedge sclk_i) if (!sel_n_i) sh = {sh[6:0], ~sh[7]};
  // Released line shows the inverse, never a stale bit
  assign miso_o = sel_n_i ? ~sh[7] : sh[7];
endmodule // spi_far_end

// ==== testbench/testbench.sv ====
// Bench for the SPI port: reset values, master bytes, interrupt.
// Assumes the far end is the model in spi_far_end.sv.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
  logic sclk_i, sclk_o, sclk_oe_o, ser_in_i, ser_out_o, ser_out_oe_o;
  logic tx_halt_i, rx_slave_select_n_i, tx_slave_select_n_o;
  logic rx_full_flag_o, bclk, mosi, miso;
  logic [3:0]  wb_sel_i;
  logic [7:0]  wb_adr_i, pb, tb, got, mb, sb;
  logic [31:0] wb_dat_i, wb_dat_o, q, seed = 32'h353E1144;
  logic [7:0]  ra [6] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h3C};
  logic [31:0] rv [6] = '{0, 32'h64, 32'hFF, 32'h2000, 32'h2000, 0};
  int n_mismatch = 0;
  int checks_done = 0;
  assign sclk_i = sclk_oe_o ? sclk_o : bclk; // Wire level of the clock
  assign ser_in_i = sclk_oe_o ? miso : mosi; // Far end or bench data
  buffered_spi_port buffered_spi_port_i (.*);
  spi_far_end spi_far_end_i (.sclk_i(sclk_i), .sel_n_i(tx_slave_select_n_o),
    .mosi_i(ser_out_o), .send_i(pb), .miso_o(miso), .got_o(got));
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Bit order as the port assembles it
  function logic [7:0] rev(input logic [7:0] b, input int o);
    return o ? {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]} : b;
  endfunction
  task chk(input string n, input logic [31:0] e, s);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // Classic single cycle; read data lands in q
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask
  task stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // Watchdog far beyond two bytes at full rate
  initial begin
    repeat (5000) @(posedge clk_i);
    n_mismatch++;
    stop_test();
  end
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, tx_halt_i} = '0;
    {wb_sel_i, rx_slave_select_n_i, rst_i, pb} = {4'hF, 2'b11, 8'h00};
    {bclk, mosi} = 2'b00;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (ra[i]) begin
      wb(1'b0, ra[i], 0);
      chk("reset value", rv[i], q);
    end
    wb(1'b1, 8'h04, 32'h3E8);
    wb(1'b1, 8'h34, 32'h1);
    wb(1'b1, 8'h14, 32'h1); // One-byte rx buffer so full shows
    // Both bit orders; master, buffers on, select out, full flag on
    for (int o = 0; o < 2; o++) begin
      wb(1'b1, 8'h00, 32'h1229 | (o * 32'h180));
      tb = 8'(xs());
      pb <= 8'(xs());
      wb(1'b1, 8'h20, {24'h0, tb});
      repeat (200) begin
        wb(1'b0, 8'h24, 0);
        if (q[30] == 1'b0 && q[29:16] == 14'h0) break;
      end
      chk("irq", 1, irq_o);
      chk("rx full", 1, rx_full_flag_o);
      chk("far end byte", rev(tb, o), got);
      wb(1'b0, 8'h1C, 0);
      chk("rx byte", rev(pb, o), q);
      chk("rx not full", 0, rx_full_flag_o);
      wb(1'b1, 8'h30, 32'hF);
      @(posedge clk_i);
      chk("irq cleared", 0, irq_o);
    end
    // Slave role, bench clock of 800 ns; empty tx buffer sends filler
    wb(1'b1, 8'h00, 32'h2A);
    mb = 8'(xs());
    for (int i = 7; i >= 0; i--) begin
      {bclk, mosi} <= {1'b0, mb[i]};
      repeat (4) @(posedge clk_i);
      bclk <= 1'b1;
      repeat (4) @(posedge clk_i);
      sb[i] = ser_out_o;
    end
    bclk <= 1'b0;
    chk("slave filler", 8'hFF, sb);
    wb(1'b0, 8'h1C, 0);
    chk("slave rx byte", mb, q);
    stop_test();
  end
endmodule // testbench
